// ### rtl/fault_supervisor_pkg.sv
// package for the output stage and supply fault supervisor
// assumes a 100 MHz core clock; used by the supervisor top level and its checker, not by the synchroniser or timer
package fault_supervisor_pkg;

  // core clock and inhibit time after commutation
  localparam int CLK_PERIOD_PS = 10000;
  localparam int INHIBIT_TIME_NS = 2000;
  localparam int INHIBIT_CYCLES = (INHIBIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INHIBIT_CNT_W = 16;

  // synchroniser depth
  localparam int SYNC_STAGES = 2;

  // comparator bundle bit positions
  localparam int CMP_PRI_UNDER_LOW = 0;
  localparam int CMP_PRI_ABOVE_HIGH = 1;
  localparam int CMP_POS_UNDER = 2;
  localparam int CMP_POS_OVER = 3;
  localparam int CMP_NEG_UNDER = 4;
  localparam int CMP_NEG_OVER = 5;
  localparam int CMP_POS_RESET = 6;
  localparam int CMP_TURN_ON_OK = 7;
  localparam int CMP_TURN_OFF_OK = 8;
  localparam int CMP_W = 9;

  // reset values of the sticky flags and of the primary and secondary fault pins
  localparam logic FLAG_RESET = 1'b0;
  localparam logic PIN_N_RESET = 1'b1;

  // supply comparator levels after synchronisation
  typedef struct packed {
    logic pri_under_low;   // primary below low undervoltage threshold
    logic pri_above_high;  // primary above high undervoltage threshold
    logic pos_under;       // secondary positive undervoltage detected
    logic pos_over;        // secondary positive overvoltage detected
    logic neg_under;       // secondary negative undervoltage detected
    logic neg_over;        // secondary negative overvoltage detected
    logic pos_reset;       // secondary positive below reset threshold
  } supply_cmp_t;

  // sticky error flags
  typedef struct packed {
    logic stage_error_flag;
    logic primary_reset_error_flag;
    logic pos_supply_under_error;
    logic pos_supply_over_error;
    logic neg_supply_under_error;
    logic neg_supply_over_error;
  } error_flags_t;

  // live monitor state
  typedef struct packed {
    logic pos_under_live;
    logic pos_over_live;
    logic neg_under_live;
    logic neg_over_live;
  } live_status_t;

  // primary supply supervision states
  typedef enum logic [0:0] {
    PRI_OK = 1'b0,
    PRI_LOW = 1'b1
  } pri_state_t;

endpackage

// ### rtl/level_sync.sv
// two flop synchroniser for a bundle of asynchronous levels
// assumes inputs are slow comparator levels, not multi-bit words
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage only feeds the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// ### rtl/inhibit_timer.sv
// down counter that holds a busy level after each start pulse
// assumes start is a one-cycle pulse in the clk domain
`timescale 1ns/10ps
`default_nettype none
module inhibit_timer #(
  parameter int CNT_W = 16,
  parameter logic [CNT_W-1:0] CYCLES = 16'd200
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic start,
  output logic busy
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // reload on start, else count down to zero
  assign next_count = start ? CYCLES : ((count != '0) ? count - 1'b1 : count);
  assign busy = (count != '0);

  // start blanked: the synchronisers leave reset with levels that need not match the command
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= CYCLES;
    end else begin
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// ### rtl/fault_supervisor.sv
// output stage monitor and supply supervisor of a gate driver
// assumes comparator and pin inputs are asynchronous; control bits come from clk-domain logic
`timescale 1ns/10ps
`default_nettype none

module fault_supervisor #(
  parameter logic [15:0] INHIBIT_CYCLES = 16'(fault_supervisor_pkg::INHIBIT_CYCLES)
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // drive command and switching events from the sequencer
  input wire logic drive_cmd_on,
  input wire logic turn_on_start,
  input wire logic hard_turn_off,
  // sensed drive outputs (asynchronous pins)
  input wire logic turn_on_drive,
  input wire logic turn_off_drive,
  // output disable pin (asynchronous)
  input wire logic output_disable_pin,
  // operating mode
  input wire logic boost_mode_a,
  input wire logic boost_mode_b,
  // configuration and commands
  input wire logic stage_monitor_disable,
  input wire logic neg_over_action_enable,
  input wire logic clear_status_cmd,
  input wire logic clear_tristate_cmd,
  input wire logic clear_errors_cmd,
  // supply comparators (asynchronous)
  input wire logic cmp_pri_under_low,
  input wire logic cmp_pri_above_high,
  input wire logic cmp_pos_under,
  input wire logic cmp_pos_over,
  input wire logic cmp_neg_under,
  input wire logic cmp_neg_over,
  input wire logic cmp_pos_reset,
  // stage outputs
  output logic output_stage_tristate,
  output logic tristate_status,
  output logic stage_fault_ctrl,
  // fault pins
  output logic primary_fault_pin_n,
  output logic secondary_fault_pin_n,
  output logic reset_ready_pin_n,
  // emergency turn-off request and secondary reset
  output logic emergency_turn_off,
  output logic secondary_reset_n,
  // status
  output fault_supervisor_pkg::error_flags_t error_flags,
  output fault_supervisor_pkg::live_status_t live_status
);

  // raw and synchronised comparator / pin levels
  logic [8:0] raw_levels;
  logic [8:0] sync_levels;
  logic sync_osd;
  logic osd_prev;
  fault_supervisor_pkg::supply_cmp_t cmp;
  fault_supervisor_pkg::pri_state_t pri_state;
  fault_supervisor_pkg::pri_state_t next_pri_state;

  // a level that is about to be set while it is still clear
  function automatic logic fresh_set(input logic next_level, input logic level);
    fresh_set = next_level & ~level;
  endfunction

  // synchronise every comparator and the sensed drive levels
  assign raw_levels = {turn_off_drive, turn_on_drive, cmp_pos_reset, cmp_neg_over, cmp_neg_under,
                       cmp_pos_over, cmp_pos_under, cmp_pri_above_high, cmp_pri_under_low};

  level_sync #(
    .WIDTH(fault_supervisor_pkg::CMP_W),
    .RESET_VALUE(9'h000)
  ) u_cmp_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(raw_levels),
    .sync_out(sync_levels)
  );

  level_sync #(
    .WIDTH(1),
    .RESET_VALUE(1'b0)
  ) u_osd_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(output_disable_pin),
    .sync_out(sync_osd)
  );

  // unpack the synchronised comparators
  assign cmp.pri_under_low = sync_levels[fault_supervisor_pkg::CMP_PRI_UNDER_LOW];
  assign cmp.pri_above_high = sync_levels[fault_supervisor_pkg::CMP_PRI_ABOVE_HIGH];
  assign cmp.pos_under = sync_levels[fault_supervisor_pkg::CMP_POS_UNDER];
  assign cmp.pos_over = sync_levels[fault_supervisor_pkg::CMP_POS_OVER];
  assign cmp.neg_under = sync_levels[fault_supervisor_pkg::CMP_NEG_UNDER];
  assign cmp.neg_over = sync_levels[fault_supervisor_pkg::CMP_NEG_OVER];
  assign cmp.pos_reset = sync_levels[fault_supervisor_pkg::CMP_POS_RESET];

  // sensed drive levels after synchronisation
  wire on_level = sync_levels[fault_supervisor_pkg::CMP_TURN_ON_OK];
  wire off_level = sync_levels[fault_supervisor_pkg::CMP_TURN_OFF_OK];

  // secondary logic reset while positive supply is below reset level
  wire sec_hold = cmp.pos_reset;
  assign secondary_reset_n = ~sec_hold;

  // output stage monitor: blanking state and its restart strobe
  wire inhibit_busy;
  wire monitor_start;

  // blanking restarts on turn-on, hard turn-off and on tristate release
  logic hz_release;
  assign monitor_start = turn_on_start | hard_turn_off | hz_release;

  inhibit_timer #(
    .CNT_W(fault_supervisor_pkg::INHIBIT_CNT_W),
    .CYCLES(INHIBIT_CYCLES)
  ) u_inhibit (
    .clk(clk),
    .nrst(nrst),
    .start(monitor_start),
    .busy(inhibit_busy)
  );

  // stage is tristated by status or by the disable pin
  wire stage_hz = tristate_status | sync_osd;
  // monitoring gate: off when disabled, inhibited or already tristated
  wire monitor_active = ~stage_monitor_disable & ~inhibit_busy & ~stage_hz;
  // turn-on output not watched in boost modes
  wire watch_on = ~(boost_mode_a | boost_mode_b);
  // expected levels follow the drive command
  wire on_mismatch = watch_on & (on_level != drive_cmd_on);
  wire off_mismatch = (off_level != ~drive_cmd_on);
  wire stage_mismatch = monitor_active & (on_mismatch | off_mismatch);

  // output disable falling edge clears the stage fault
  wire osd_fall = osd_prev & ~sync_osd;
  // set of tristate status wins over a same-cycle clear
  wire next_tristate = stage_mismatch | (tristate_status & ~clear_tristate_cmd);
  wire hz_rise = fresh_set(next_tristate, tristate_status);
  // release reloads the blanking at the same edge, so no unblanked cycle follows it
  assign hz_release = tristate_status & ~next_tristate;
  // stage fault set wins over clear
  wire next_stage_fault = hz_rise | (stage_fault_ctrl & ~(clear_status_cmd | osd_fall));

  // output stage leaves tristate only once status is clear
  assign output_stage_tristate = stage_hz;

  // tristate status, stage fault and disable pin history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tristate_status <= fault_supervisor_pkg::FLAG_RESET;
      stage_fault_ctrl <= fault_supervisor_pkg::FLAG_RESET;
      osd_prev <= 1'b0;
    end else begin
      tristate_status <= next_tristate;
      stage_fault_ctrl <= next_stage_fault;
      osd_prev <= sync_osd;
    end
  end

  // primary supply state
  // low until the high threshold is crossed again
  always_comb begin
    next_pri_state = pri_state;
    case (pri_state)
      fault_supervisor_pkg::PRI_OK: begin
        if (cmp.pri_under_low) begin
          next_pri_state = fault_supervisor_pkg::PRI_LOW;
        end
      end
      fault_supervisor_pkg::PRI_LOW: begin
        if (cmp.pri_above_high && !cmp.pri_under_low) begin
          next_pri_state = fault_supervisor_pkg::PRI_OK;
        end
      end
      default: next_pri_state = fault_supervisor_pkg::PRI_OK;
    endcase
  end

  // one-cycle strobe when the primary supply has recovered
  wire pri_recover = (pri_state == fault_supervisor_pkg::PRI_LOW) &&
                     (next_pri_state == fault_supervisor_pkg::PRI_OK);

  // secondary supply monitors: live conditions
  logic pos_under_cond;
  logic pos_over_cond;
  logic neg_under_cond;
  logic neg_over_cond;

  // comparator levels carry the hysteresis; conditions track them, forced clear in secondary reset
  wire next_pos_under = cmp.pos_under & ~sec_hold;
  wire next_pos_over = cmp.pos_over & ~sec_hold;
  wire next_neg_under = cmp.neg_under & ~sec_hold;
  wire next_neg_over = cmp.neg_over & ~sec_hold;

  // negative overvoltage acts only when enabled
  wire neg_over_acts = neg_over_cond & neg_over_action_enable;
  wire sec_fault = pos_under_cond | pos_over_cond | neg_under_cond | neg_over_acts;

  // live detection state
  assign live_status.pos_under_live = pos_under_cond;
  assign live_status.pos_over_live = pos_over_cond;
  assign live_status.neg_under_live = neg_under_cond;
  assign live_status.neg_over_live = neg_over_cond;

  // sticky flags: any new detection wins over software clear
  fault_supervisor_pkg::error_flags_t next_flags;
  fault_supervisor_pkg::error_flags_t set_flags;
  assign set_flags.stage_error_flag = hz_rise;
  assign set_flags.primary_reset_error_flag = pri_recover;
  assign set_flags.pos_supply_under_error = fresh_set(next_pos_under, pos_under_cond);
  assign set_flags.pos_supply_over_error = fresh_set(next_pos_over, pos_over_cond);
  assign set_flags.neg_supply_under_error = fresh_set(next_neg_under, neg_under_cond);
  assign set_flags.neg_supply_over_error = fresh_set(next_neg_over, neg_over_cond);
  assign next_flags = set_flags | (clear_errors_cmd ? '0 : error_flags);

  // primary state and live secondary conditions
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pri_state <= fault_supervisor_pkg::PRI_OK;
      pos_under_cond <= 1'b0;
      pos_over_cond <= 1'b0;
      neg_under_cond <= 1'b0;
      neg_over_cond <= 1'b0;
    end else begin
      pri_state <= next_pri_state;
      pos_under_cond <= next_pos_under;
      pos_over_cond <= next_pos_over;
      neg_under_cond <= next_neg_under;
      neg_over_cond <= next_neg_over;
    end
  end

  // sticky error flags; only the clear command or reset drops them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      error_flags <= '0;
    end else begin
      error_flags <= next_flags;
    end
  end

  // pins and turn-off request
  wire pri_low = (pri_state == fault_supervisor_pkg::PRI_LOW);
  wire next_primary_fault_n = ~(stage_fault_ctrl | hz_rise);
  wire next_secondary_fault_n = ~sec_fault;
  wire next_reset_ready_n = ~(pri_low | cmp.pri_under_low);
  // turn-off request starts at the same edge as reset/ready falls, not one later
  wire next_emergency = pri_low | cmp.pri_under_low | sec_fault;

  // fault pins; reset/ready stays low through reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      primary_fault_pin_n <= fault_supervisor_pkg::PIN_N_RESET;
      secondary_fault_pin_n <= fault_supervisor_pkg::PIN_N_RESET;
      reset_ready_pin_n <= 1'b0;
    end else begin
      primary_fault_pin_n <= next_primary_fault_n;
      secondary_fault_pin_n <= next_secondary_fault_n;
      reset_ready_pin_n <= next_reset_ready_n;
    end
  end

  // turn-off request to the sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      emergency_turn_off <= 1'b0;
    end else begin
      emergency_turn_off <= next_emergency;
    end
  end

endmodule
`default_nettype wire

// ### tb/fault_supervisor_checker.sv
// port assertions for the fault supervisor
// assumes binding into fault_supervisor, one clock domain
`timescale 1ns/10ps
`default_nettype none
module fault_supervisor_checker #(
  parameter logic [15:0] INHIBIT_CYCLES = 16'h00c8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // commands and configuration
  input wire logic clear_status_cmd,
  input wire logic clear_tristate_cmd,
  input wire logic stage_monitor_disable,
  input wire logic neg_over_action_enable,
  input wire logic cmp_pos_reset,
  // outputs
  input wire logic output_stage_tristate,
  input wire logic tristate_status,
  input wire logic stage_fault_ctrl,
  input wire logic primary_fault_pin_n,
  input wire logic secondary_fault_pin_n,
  input wire logic reset_ready_pin_n,
  input wire logic emergency_turn_off,
  input wire logic secondary_reset_n,
  input wire fault_supervisor_pkg::error_flags_t error_flags,
  input wire fault_supervisor_pkg::live_status_t live_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // cycles since the stage left tristate, saturating
  logic hz_prev;
  logic [15:0] since_rel;
  logic [15:0] next_since_rel;
  assign next_since_rel = (hz_prev && !tristate_status) ? 16'h0001 :
                          ((since_rel != 16'hffff) ? since_rel + 16'h0001 : since_rel);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hz_prev <= 1'b0;
      since_rel <= 16'hffff;
    end else begin
      hz_prev <= tristate_status;
      since_rel <= next_since_rel;
    end
  end
  blank_hold_a: assert property (since_rel <= INHIBIT_CYCLES |-> !$rose(tristate_status))
    else $error("monitor active during blanking");
  // stage events and tristate handling
  stage_event_a: assert property ($rose(tristate_status) |-> ##[0:1] (stage_fault_ctrl && error_flags[5]) ##[0:1] !primary_fault_pin_n)
    else $error("stage event missing");
  clear_fault_a: assert property (clear_status_cmd ##1 !$rose(tristate_status) |-> !stage_fault_ctrl)
    else $error("stage fault not cleared");
  hz_hold_a: assert property (tristate_status && !clear_tristate_cmd |=> tristate_status)
    else $error("tristate left early");
  hiz_mute_a: assert property (output_stage_tristate |=> !$rose(tristate_status))
    else $error("monitor active in tristate");
  mon_off_a: assert property (stage_monitor_disable |=> !$rose(tristate_status))
    else $error("monitor active while disabled");
  // supply supervision
  pos_under_a: assert property ($rose(live_status[3]) |-> error_flags[3] ##1 (!secondary_fault_pin_n && emergency_turn_off))
    else $error("pos under action missing");
  pos_over_a: assert property ($rose(live_status[2]) |-> error_flags[2] ##1 (!secondary_fault_pin_n && emergency_turn_off))
    else $error("pos over action missing");
  neg_under_a: assert property ($rose(live_status[1]) |-> error_flags[1] ##1 (!secondary_fault_pin_n && emergency_turn_off))
    else $error("neg under action missing");
  neg_act_a: assert property ($rose(live_status[0]) && neg_over_action_enable |=> !secondary_fault_pin_n && emergency_turn_off)
    else $error("neg over action missing");
  neg_quiet_a: assert property ($rose(live_status[0]) && !neg_over_action_enable && live_status[3:1] == 3'h0 |-> error_flags[0] ##1 secondary_fault_pin_n)
    else $error("neg over acted while off");
  rr_low_a: assert property ($fell(reset_ready_pin_n) |-> emergency_turn_off)
    else $error("no turn-off with primary low");
  sec_reset_a: assert property ($past(nrst, 3) |-> secondary_reset_n == !$past(cmp_pos_reset, 2))
    else $error("secondary reset timing");
endmodule
`default_nettype wire

// ### tb/booster_model.sv
// booster stage model that returns the two sensed drive levels
// assumes the command is a clk-domain level; stuck legs are bench faults
`timescale 1ns/10ps
`default_nettype none
module booster_model (
  // clock
  input wire logic clk,
  // command and bench controls
  input wire logic drive_cmd_on,
  input wire logic slow,
  input wire logic [1:0] stuck,
  // sensed levels
  output logic turn_on_drive,
  output logic turn_off_drive
);
  logic lag;
  logic cmd;
  // one-cycle late copy for a slow booster
  always_ff @(posedge clk) lag <= drive_cmd_on;
  // legs follow the command, a stuck leg shows the wrong level
  assign cmd = slow ? lag : drive_cmd_on;
  assign turn_on_drive = cmd ^ stuck[0];
  assign turn_off_drive = !cmd ^ stuck[1];
endmodule
`default_nettype wire

// ### tb/fault_supervisor_test.sv
// self-checking bench for the fault supervisor and a booster model
// assumes a short inhibit time and the checker bound below
`timescale 1ns/10ps
`default_nettype none
module fault_supervisor_test;
  localparam logic [15:0] INH = 16'h0004;
  logic clk = 1'b0, nrst = 1'b0, drive_cmd_on = 1'b0, turn_on_start = 1'b0, hard_turn_off = 1'b0;
  logic output_disable_pin = 1'b0, boost_mode_a = 1'b0, boost_mode_b = 1'b0, stage_monitor_disable = 1'b0;
  logic neg_over_action_enable = 1'b0, clear_status_cmd = 1'b0, clear_tristate_cmd = 1'b0, clear_errors_cmd = 1'b0;
  logic cmp_pri_under_low = 1'b0, cmp_pri_above_high = 1'b1, cmp_pos_under = 1'b0, cmp_pos_over = 1'b0;
  logic cmp_neg_under = 1'b0, cmp_neg_over = 1'b0, cmp_pos_reset = 1'b0, slow = 1'b0;
  logic [1:0] stuck = 2'h0;
  logic turn_on_drive, turn_off_drive, output_stage_tristate, tristate_status, stage_fault_ctrl;
  logic primary_fault_pin_n, secondary_fault_pin_n, reset_ready_pin_n, emergency_turn_off, secondary_reset_n;
  fault_supervisor_pkg::error_flags_t error_flags;
  fault_supervisor_pkg::live_status_t live_status;
  // expected state and result notes
  logic e_hz = 1'b0, e_od = 1'b0, e_sfc = 1'b0, e_pri = 1'b0, e_srn = 1'b1;
  logic [5:0] e_err = 6'h00;
  logic [3:0] e_live = 4'h0;
  logic [17:0] q[$];
  int num_errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  fault_supervisor #(.INHIBIT_CYCLES(INH)) u_fault_supervisor (.clk, .nrst, .drive_cmd_on, .turn_on_start,
    .hard_turn_off, .turn_on_drive, .turn_off_drive, .output_disable_pin, .boost_mode_a, .boost_mode_b,
    .stage_monitor_disable, .neg_over_action_enable, .clear_status_cmd, .clear_tristate_cmd, .clear_errors_cmd,
    .cmp_pri_under_low, .cmp_pri_above_high, .cmp_pos_under, .cmp_pos_over, .cmp_neg_under, .cmp_neg_over,
    .cmp_pos_reset, .output_stage_tristate, .tristate_status, .stage_fault_ctrl, .primary_fault_pin_n,
    .secondary_fault_pin_n, .reset_ready_pin_n, .emergency_turn_off, .secondary_reset_n, .error_flags, .live_status);
  booster_model u_booster_model (.clk, .drive_cmd_on, .slow, .stuck, .turn_on_drive, .turn_off_drive);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] outputs exp %h seen %h", exp, seen);
    end
  endtask
  // pins follow the expected conditions
  task automatic note;
    logic sec;
    sec = |e_live[3:1] || (e_live[0] && neg_over_action_enable);
    q.push_back({e_hz || e_od, e_hz, e_sfc, !e_sfc, !sec, !e_pri, sec || e_pri, e_srn, e_err, e_live});
  endtask
  // oldest note against settled outputs
  always @(negedge clk) begin
    if (q.size() > 0) begin
      chk({output_stage_tristate, tristate_status, stage_fault_ctrl, primary_fault_pin_n,
        secondary_fault_pin_n, reset_ready_pin_n, emergency_turn_off, secondary_reset_n, error_flags, live_status},
        q.pop_front());
    end
  end
  task automatic wait_hz;
    for (int i = 0; i < 12 && tristate_status !== 1'b1; i++) @(negedge clk);
    if (tristate_status !== 1'b1) begin
      num_errors++;
      $display("[FAIL] tristate_status exp 1 seen %b", tristate_status);
      close_out();
    end
  endtask
  // stuck leg, tristate, hold, release
  task automatic fault(input logic [1:0] s);
    stuck <= s;
    wait_hz();
    @(posedge clk);
    stuck <= 2'h0;
    {e_hz, e_sfc, e_err[5]} = 3'h7;
    note();
    cyc(4);
    note();
    clear_tristate_cmd <= 1'b1;
    cyc(1);
    clear_tristate_cmd <= 1'b0;
    cyc(3);
    e_hz = 1'b0;
    note();
    cyc(6);
  endtask
  // switching event then command change
  task automatic sw(input logic on);
    slow <= 1'($urandom_range(0, 1));
    turn_on_start <= on;
    hard_turn_off <= !on;
    cyc(1);
    {turn_on_start, hard_turn_off} <= 2'h0;
    drive_cmd_on <= on;
    cyc(8);
    note();
  endtask
  initial begin
    void'($urandom(71363));
    cyc(3);
    nrst <= 1'b1;
    cyc(8);
    note();
    fault(2'($urandom_range(1, 3)));
    output_disable_pin <= 1'b1;
    cyc(1);
    stuck <= 2'h3;
    cyc(6);
    e_od = 1'b1;
    note();
    stuck <= 2'h0;
    cyc(3);
    output_disable_pin <= 1'b0;
    cyc(6);
    {e_od, e_sfc} = 2'h0;
    note();
    fault(2'h1);
    clear_status_cmd <= 1'b1;
    cyc(1);
    clear_status_cmd <= 1'b0;
    cyc(2);
    e_sfc = 1'b0;
    note();
    {boost_mode_a, boost_mode_b} <= $urandom_range(0, 1) ? 2'h2 : 2'h1;
    sw(1'b1);
    stuck <= 2'h1;
    cyc(8);
    note();
    fault(2'h2);
    {boost_mode_a, boost_mode_b} <= 2'h0;
    sw(1'b0);
    stage_monitor_disable <= 1'b1;
    stuck <= 2'h3;
    cyc(8);
    note();
    stuck <= 2'h0;
    cyc(4);
    stage_monitor_disable <= 1'b0;
    for (int en = 0; en < 2; en++) begin
      for (int k = 0; k < 4; k++) begin
        neg_over_action_enable <= en[0];
        {cmp_pos_under, cmp_pos_over, cmp_neg_under, cmp_neg_over} <= 4'h8 >> k;
        cyc(6);
        e_live = 4'h8 >> k;
        e_err[3:0] = e_err[3:0] | e_live;
        note();
        {cmp_pos_under, cmp_pos_over, cmp_neg_under, cmp_neg_over} <= 4'h0;
        cyc(6);
        e_live = 4'h0;
        note();
        clear_errors_cmd <= 1'b1;
        cyc(1);
        clear_errors_cmd <= 1'b0;
        cyc(2);
        e_err = 6'h00;
        note();
      end
    end
    {cmp_pri_under_low, cmp_pri_above_high} <= 2'h2;
    cyc(6);
    e_pri = 1'b1;
    note();
    {cmp_pri_under_low, cmp_pri_above_high} <= 2'h1;
    cyc(6);
    {e_pri, e_err[4]} = 2'h1;
    note();
    cmp_pos_reset <= 1'b1;
    cyc(4);
    e_srn = 1'b0;
    note();
    cmp_pos_reset <= 1'b0;
    cyc(4);
    e_srn = 1'b1;
    note();
    cyc(2);
    close_out();
  end
endmodule
bind fault_supervisor fault_supervisor_checker #(.INHIBIT_CYCLES(INHIBIT_CYCLES)) u_fault_supervisor_checker (
  .clk, .nrst, .clear_status_cmd, .clear_tristate_cmd, .stage_monitor_disable, .neg_over_action_enable,
  .cmp_pos_reset, .output_stage_tristate, .tristate_status, .stage_fault_ctrl, .primary_fault_pin_n,
  .secondary_fault_pin_n, .reset_ready_pin_n, .emergency_turn_off, .secondary_reset_n, .error_flags, .live_status);
`default_nettype wire
